// [pkg/pspc_pkg.sv]
// constants for the programming spi port configuration block
package pspc_pkg;

  // strap decode values
  localparam logic ROLE_SLAVE = 1'b0;
  localparam logic ROLE_MASTER = 1'b1;
  localparam logic PORT_OFF = 1'b0;
  localparam logic PORT_ON = 1'b1;

  // values after reset
  localparam logic RST_ROLE = 1'b0;
  localparam logic RST_EN = 1'b0;
  localparam logic RST_FAB_EN = 1'b1;

  // core cycles after reset release before the straps are latched
  localparam logic [1:0] CAP_WAIT = 2'h2;

  // power-up completion delay before the fabric may take the pins
  localparam int CORE_CLK_MHZ = 50;
  localparam int PWRUP_NS = 1000;
  localparam int PWRUP_CYC_INT = (PWRUP_NS * CORE_CLK_MHZ + 999) / 1000;
  localparam logic [7:0] PWRUP_CYC = PWRUP_CYC_INT[7:0];

  // port owner
  typedef enum logic [1:0] {
    PSPC_OWN_NONE,
    PSPC_OWN_CTRL,
    PSPC_OWN_FABRIC
  } pspc_owner_t;

endpackage

// [hdl/pspc_port_cfg.sv]
// strap capture, ownership and pin steering for the programming spi port
`timescale 1ns/10ps
module pspc_port_cfg (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_N_I,
  // board straps and pins
  input wire logic SPI_EN_I,
  input wire logic SPI_ROLE_STRAP_I,
  input wire logic TEST_RESET_PIN_I,
  input wire logic SUSPEND_CFG_I,
  // spi pins
  input wire logic SCK_I,
  output logic SCK_O,
  output logic SCK_OE_O,
  input wire logic SS_N_I,
  output logic SS_N_O,
  output logic SS_N_OE_O,
  input wire logic SDI_I,
  output logic SDO_O,
  output logic SDO_OE_O,
  // system controller side
  input wire logic CTRL_SDO_I,
  input wire logic CTRL_SCK_I,
  input wire logic CTRL_SS_N_I,
  output logic CTRL_SCK_O,
  output logic CTRL_SCK_RISE_O,
  output logic CTRL_SS_N_O,
  output logic CTRL_SDI_O,
  output logic CTRL_AWAKE_O,
  output logic SLAVE_PROG_OK_O,
  output logic FLASH_INIT_OK_O,
  // fabric side
  input wire logic FAB_SCK_I,
  input wire logic FAB_SCK_OE_I,
  input wire logic FAB_SS_N_I,
  input wire logic FAB_SS_N_OE_I,
  input wire logic FAB_SDO_I,
  input wire logic FAB_SDO_OE_I,
  output logic FAB_SDI_O,
  output logic FAB_OWNS_O,
  // programming results
  input wire logic PROG_DONE_I,
  input wire logic PROG_SEC_ONLY_I,
  output logic FABRIC_ENABLED_O
);

  ////////////////////////////////////////////////////////////////
  // synchronisers
  logic [1:0] en_sync, role_sync, trst_sync, sck_sync, ss_sync, sdi_sync;
  logic sck_last;

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      en_sync <= 2'h0;
      role_sync <= 2'h0;
      trst_sync <= 2'h0;
      sck_sync <= 2'h0;
      ss_sync <= 2'h3;
      sdi_sync <= 2'h0;
      sck_last <= 1'b0;
    end
    else
    begin
      en_sync <= {en_sync[0], SPI_EN_I};
      role_sync <= {role_sync[0], SPI_ROLE_STRAP_I};
      trst_sync <= {trst_sync[0], TEST_RESET_PIN_I};
      sck_sync <= {sck_sync[0], SCK_I};
      ss_sync <= {ss_sync[0], SS_N_I};
      sdi_sync <= {sdi_sync[0], SDI_I};
      sck_last <= sck_sync[1];
    end
  end

  ////////////////////////////////////////////////////////////////
  // strap capture after reset release
  logic captured, role, port_en;
  logic next_captured, next_role, next_port_en;
  logic [1:0] cap_wait, next_cap_wait;

  always_comb
  begin
    next_captured = captured;
    next_role = role;
    next_port_en = port_en;
    next_cap_wait = cap_wait;
    if (!captured)
    begin
      // wait for synchronisers to fill, then latch once
      if (cap_wait == pspc_pkg::CAP_WAIT)
      begin
        next_captured = 1'b1;
        next_role = role_sync[1];
        next_port_en = en_sync[1];
      end
      else
      begin
        next_cap_wait = cap_wait + 2'h1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      captured <= 1'b0;
      role <= pspc_pkg::RST_ROLE;
      port_en <= pspc_pkg::RST_EN;
      cap_wait <= 2'h0;
    end
    else
    begin
      captured <= next_captured;
      role <= next_role;
      port_en <= next_port_en;
      cap_wait <= next_cap_wait;
    end
  end

  // live enable strap still tristates outputs, two core cycles later through its synchroniser
  logic en_live;
  assign en_live = en_sync[1] && port_en;

  ////////////////////////////////////////////////////////////////
  // owner state machine and power-up delay
  pspc_pkg::pspc_owner_t owner, next_owner;
  logic [7:0] pwr_cnt, next_pwr_cnt;

  always_comb
  begin
    next_owner = owner;
    next_pwr_cnt = pwr_cnt;
    case (owner)
      pspc_pkg::PSPC_OWN_NONE:
      begin
        if (captured)
        begin
          next_owner = pspc_pkg::PSPC_OWN_CTRL;
        end
      end
      pspc_pkg::PSPC_OWN_CTRL:
      begin
        if (port_en && role == pspc_pkg::ROLE_MASTER)
        begin
          if (pwr_cnt == pspc_pkg::PWRUP_CYC - 8'h1)
          begin
            next_owner = pspc_pkg::PSPC_OWN_FABRIC;
          end
          else
          begin
            next_pwr_cnt = pwr_cnt + 8'h1;
          end
        end
      end
      pspc_pkg::PSPC_OWN_FABRIC:
      begin
        next_owner = pspc_pkg::PSPC_OWN_FABRIC;
      end
      default:
      begin
        next_owner = pspc_pkg::PSPC_OWN_NONE;
      end
    endcase
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      owner <= pspc_pkg::PSPC_OWN_NONE;
      pwr_cnt <= 8'h0;
    end
    else
    begin
      owner <= next_owner;
      pwr_cnt <= next_pwr_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////
  // fabric disable after security-only image
  logic fab_en, next_fab_en;

  always_comb
  begin
    next_fab_en = fab_en;
    if (PROG_DONE_I)
    begin
      next_fab_en = !PROG_SEC_ONLY_I;
    end
  end

  always_ff @(posedge CORE_CLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      fab_en <= pspc_pkg::RST_FAB_EN;
    end
    else
    begin
      fab_en <= next_fab_en;
    end
  end

  ////////////////////////////////////////////////////////////////
  // pin steering
  logic slave_ok, fab_owns, ctrl_master, ss_hi;
  assign slave_ok = captured && port_en == pspc_pkg::PORT_ON && role == pspc_pkg::ROLE_SLAVE;
  assign fab_owns = owner == pspc_pkg::PSPC_OWN_FABRIC && role == pspc_pkg::ROLE_MASTER;
  assign ctrl_master = captured && role == pspc_pkg::ROLE_MASTER && !fab_owns;
  assign ss_hi = ss_sync[1];

  always_comb
  begin
    SCK_O = 1'b0;
    SCK_OE_O = 1'b0;
    SS_N_O = 1'b1;
    SS_N_OE_O = 1'b0;
    SDO_O = 1'b0;
    SDO_OE_O = 1'b0;
    if (en_live)
    begin
      if (fab_owns)
      begin
        SCK_O = FAB_SCK_I;
        SCK_OE_O = FAB_SCK_OE_I;
        SS_N_O = FAB_SS_N_I;
        SS_N_OE_O = FAB_SS_N_OE_I;
        SDO_O = FAB_SDO_I;
        SDO_OE_O = FAB_SDO_OE_I;
      end
      else if (ctrl_master)
      begin
        SCK_O = CTRL_SCK_I;
        SCK_OE_O = 1'b1;
        SS_N_O = CTRL_SS_N_I;
        SS_N_OE_O = 1'b1;
        SDO_O = CTRL_SDO_I;
        SDO_OE_O = 1'b1;
      end
      else if (slave_ok && !ss_hi)
      begin
        SDO_O = CTRL_SDO_I;
        SDO_OE_O = 1'b1;
      end
    end
  end

  assign CTRL_SCK_O = sck_sync[1];
  assign CTRL_SCK_RISE_O = slave_ok && sck_sync[1] && !sck_last;
  assign CTRL_SS_N_O = slave_ok ? ss_hi : 1'b1;
  assign CTRL_SDI_O = (fab_owns ? 1'b0 : sdi_sync[1]);
  assign FAB_SDI_O = fab_owns ? sdi_sync[1] : 1'b0;
  assign FAB_OWNS_O = fab_owns;
  assign SLAVE_PROG_OK_O = slave_ok;
  assign FLASH_INIT_OK_O = captured && role == pspc_pkg::ROLE_MASTER;
  assign CTRL_AWAKE_O = !SUSPEND_CFG_I || trst_sync[1];
  assign FABRIC_ENABLED_O = fab_en;

  ////////////////////////////////////////////////////////////////
  // assertions
  a_role_held: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    $past(captured) |-> $stable(role)) else $error("role changed while running");
  a_slave_gate: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    SLAVE_PROG_OK_O |-> (port_en && !role)) else $error("slave accepted with bad straps");
  a_tristate_off: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    !$past(SPI_EN_I, 2) |-> !(SCK_OE_O || SS_N_OE_O || SDO_OE_O)) else $error("output driven while disabled");
  a_no_fab_slave: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (captured && !role) |-> (!FAB_OWNS_O && !FAB_SDI_O)) else $error("fabric reached pins in slave role");
  a_no_flash_init: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (captured && !role) |-> !FLASH_INIT_OK_O) else $error("flash init in slave role");
  a_handover: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    $rose(captured) && port_en && role |-> ##[1:60] FAB_OWNS_O) else $error("no handover to fabric");
  a_ss_tristate: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (slave_ok && $past(SS_N_I, 2)) |-> !SDO_OE_O) else $error("sdo driven while deselected");
  a_suspend: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (SUSPEND_CFG_I && !$past(TEST_RESET_PIN_I, 2)) |-> !CTRL_AWAKE_O) else $error("left suspend with pin low");
  a_sec_only: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (PROG_DONE_I && PROG_SEC_ONLY_I) |=> !FABRIC_ENABLED_O) else $error("fabric not disabled");
  a_capture: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    $rose(captured) |-> role == $past(role_sync[1])) else $error("strap capture wrong");

  c_slave: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) SLAVE_PROG_OK_O && SDO_OE_O);
  c_fab: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) FAB_OWNS_O);
  c_sec: cover property (@(posedge CORE_CLK_I) disable iff (!RST_N_I) PROG_DONE_I && PROG_SEC_ONLY_I);

endmodule

// [dv/pspc_host_model.sv]
// external programming master: drives straps, device reset and the spi lines
`timescale 1ns/10ps
module pspc_host_model (
  // core clock for reset timing
  input wire logic clk_i,
  // straps and reset
  output logic rst_n_o,
  output logic en_o,
  output logic role_o,
  // spi lines
  output logic sck_o,
  output logic ss_n_o,
  output logic sdi_o
);
  initial
  begin
    {rst_n_o, en_o, role_o} = 3'h0;
    {sck_o, ss_n_o, sdi_o} = 3'h7;
  end
  //////////////////////////////////////////////////
  // straps are latched through a reset; only the enable strap also acts live, to tristate the port
  task automatic boot(input logic en, input logic role);
    @(negedge clk_i);
    rst_n_o = 1'b0;
    {en_o, role_o} = {en, role};
    repeat (8) @(negedge clk_i);
    rst_n_o = 1'b1;
  endtask
  // mode 3 byte, msb first; sck stands still and sdi floats high between frames
  task automatic frame(input logic [7:0] d);
    #7 ss_n_o = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      #80 sck_o = 1'b0;
      sdi_o = d[i];
      #80 sck_o = 1'b1;
    end
    #80 {ss_n_o, sdi_o} = 2'h3;
  endtask
endmodule

// [dv/tb_pspc_port_cfg.sv]
// self-checking bench for the programming spi port configuration block
`timescale 1ns/10ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_pspc_port_cfg;
  logic clk = 1'b0;
  logic trst = 1'b0;
  logic susp = 1'b0;
  logic fab_d = 1'b0;
  logic fab_oe = 1'b0;
  logic done = 1'b0;
  logic sec = 1'b0;
  logic ctrl_sdo = 1'b1;
  logic ss_o, ctrl_sck, ctrl_ss;
  logic rst_n, en, role, sck, ss_n, sdi, sdo, sdo_oe, sck_o, sck_oe, ss_oe;
  logic rise, csdi, awake, slv_ok, fl_ok, owns, fab_en, fab_sdi;
  logic [7:0] rx = 8'h00;
  int nrise = 0;
  int errors = 0;
  int checks = 0;
  always #10 clk = ~clk;
  pspc_host_model u_host (.clk_i(clk), .rst_n_o(rst_n), .en_o(en), .role_o(role), .sck_o(sck),
    .ss_n_o(ss_n), .sdi_o(sdi));
  pspc_port_cfg u_dut (.CORE_CLK_I(clk), .RST_N_I(rst_n), .SPI_EN_I(en), .SPI_ROLE_STRAP_I(role),
    .TEST_RESET_PIN_I(trst), .SUSPEND_CFG_I(susp), .SCK_I(sck), .SCK_O(sck_o), .SCK_OE_O(sck_oe),
    .SS_N_I(ss_n), .SS_N_O(ss_o), .SS_N_OE_O(ss_oe), .SDI_I(sdi), .SDO_O(sdo), .SDO_OE_O(sdo_oe),
    .CTRL_SDO_I(ctrl_sdo), .CTRL_SCK_I(1'b1), .CTRL_SS_N_I(1'b1), .CTRL_SCK_O(ctrl_sck),
    .CTRL_SCK_RISE_O(rise),
    .CTRL_SS_N_O(ctrl_ss), .CTRL_SDI_O(csdi), .CTRL_AWAKE_O(awake), .SLAVE_PROG_OK_O(slv_ok),
    .FLASH_INIT_OK_O(fl_ok), .FAB_SCK_I(fab_d), .FAB_SCK_OE_I(fab_oe), .FAB_SS_N_I(fab_d),
    .FAB_SS_N_OE_I(fab_oe), .FAB_SDO_I(fab_d), .FAB_SDO_OE_I(fab_oe), .FAB_SDI_O(fab_sdi),
    .FAB_OWNS_O(owns), .PROG_DONE_I(done), .PROG_SEC_ONLY_I(sec), .FABRIC_ENABLED_O(fab_en));
  // collect bits the controller sees on each sck rise
  always @(negedge clk)
    if (rise === 1'b1)
    begin
      rx <= {rx[6:0], csdi};
      nrise <= nrise + 1;
    end
  //////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic test_slave();
    u_host.boot(1'b1, 1'b0);
    cyc(80);
    `CHK(slv_ok, 1'b1)
    `CHK(fl_ok, 1'b0)
    `CHK(owns, 1'b0)
    `CHK(sdo_oe, 1'b0)
    nrise = 0;
    fork
      u_host.frame(8'ha5);
      begin
        cyc(6);
        `CHK(sdo_oe, 1'b1)
        `CHK({sdo, ctrl_ss}, 2'h2)
      end
    join
    cyc(5);
    `CHK(rx, 8'ha5)
    `CHK(nrise, 8)
    `CHK({ctrl_sck, ctrl_ss}, 2'h3)
    `CHK(sdo_oe, 1'b0)
    u_host.role_o = 1'b1;
    cyc(10);
    `CHK(slv_ok, 1'b1)
    `CHK(fl_ok, 1'b0)
    $display("test_slave done");
  endtask
  task automatic test_master();
    int n;
    {fab_d, fab_oe} = 2'h3;
    u_host.boot(1'b1, 1'b1);
    cyc(20);
    `CHK(owns, 1'b0)
    n = 0;
    while (owns !== 1'b1 && n < 200)
    begin
      cyc(1);
      n++;
    end
    if (n == 200)
    begin
      errors++;
      print_verdict();
    end
    `CHK(n > 20, 1'b1)
    `CHK(fl_ok, 1'b1)
    `CHK(slv_ok, 1'b0)
    `CHK({sck_oe, sck_o, ss_o, fab_sdi}, 4'hf)
    u_host.en_o = 1'b0;
    cyc(3);
    `CHK({sck_oe, ss_oe, sdo_oe}, 3'h0)
    $display("test_master done");
  endtask
  task automatic test_off();
    u_host.boot(1'b0, 1'b0);
    cyc(80);
    `CHK(slv_ok, 1'b0)
    `CHK({sck_oe, ss_oe, sdo_oe}, 3'h0)
    $display("test_off done");
  endtask
  task automatic test_wake_secure();
    susp = 1'b1;
    cyc(4);
    `CHK(awake, 1'b0)
    trst = 1'b1;
    cyc(4);
    `CHK(awake, 1'b1)
    trst = 1'b0;
    cyc(4);
    `CHK(awake, 1'b0)
    `CHK(fab_en, 1'b1)
    {done, sec} = 2'h3;
    cyc(1);
    {done, sec} = 2'h0;
    cyc(3);
    `CHK(fab_en, 1'b0)
    done = 1'b1;
    cyc(1);
    done = 1'b0;
    cyc(3);
    `CHK(fab_en, 1'b1)
    $display("test_wake_secure done");
  endtask
  initial
  begin
    test_slave();
    test_master();
    test_off();
    test_wake_secure();
    print_verdict();
  end
endmodule
